// ==== osc_pll_pkg.sv ====
package osc_pll_pkg;

   // Register offsets on the internal register port.
   localparam logic [6:0] ADDR_FRAC_LOW = 7'h03;
   localparam logic [6:0] ADDR_FRAC_MID = 7'h04;
   localparam logic [6:0] ADDR_FRAC_HIGH = 7'h05;
   localparam logic [6:0] ADDR_INTEGER_PLL_INPUT_HALVE = 7'h06;
   localparam logic [6:0] ADDR_POSTDIV_FRACMODE = 7'h07;
   localparam logic [6:0] ADDR_POWER_DOWN = 7'h1e;

   // Field positions.
   localparam int OSC_PD_BIT = 3;
   localparam int PLL_PD_BIT = 0;
   localparam int HALVE_BIT = 4;
   localparam int FRAC_EN_BIT = 2;
   localparam int FRAC_WIDTH = 22;
   localparam int INT_WIDTH = 4;

   // Values after reset.
   localparam logic [7:0] RST_FRAC_LOW = 8'h21;
   localparam logic [7:0] RST_FRAC_MID = 8'hfd;
   localparam logic [5:0] RST_FRAC_HIGH = 6'h36;
   localparam logic [3:0] RST_INTEGER = 4'h7;
   localparam logic RST_HALVE = 1'b0;
   localparam logic [1:0] RST_POST_SEL = 2'h2;
   localparam logic RST_FRAC_EN = 1'b1;
   localparam logic RST_OSC_PD = 1'b1;
   localparam logic RST_PLL_PD = 1'b1;

   // Clock source codes for the master and auxiliary clock pins.
   localparam logic [1:0] SRC_OSC = 2'h0;
   localparam logic [1:0] SRC_CLOCK_A = 2'h1;
   localparam logic [1:0] SRC_CLOCK_B = 2'h2;

   // One complete PLL setting.
   typedef struct packed {
      logic [INT_WIDTH-1:0] integer_mult;
      logic [FRAC_WIDTH-1:0] frac_mult;
      logic [1:0] pll_post_divider_sel;
      logic pll_fraction_enable;
      logic pll_input_halve;
   } pll_setting_t;

   localparam pll_setting_t RST_SETTING = '{
      integer_mult: RST_INTEGER,
      frac_mult: {RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW},
      pll_post_divider_sel: RST_POST_SEL,
      pll_fraction_enable: RST_FRAC_EN,
      pll_input_halve: RST_HALVE
   };

   // Clock routing requests from the audio interface and output logic.
   typedef struct packed {
      logic [1:0] master_src;
      logic [1:0] aux_src;
      logic master_pin_output;
      logic aux_pin_enable;
   } clock_route_t;

   // Multiplication ratio in 4.22 fixed point; fraction dropped in
   // integer mode so the two contributions only add when enabled.
   function automatic logic [INT_WIDTH+FRAC_WIDTH-1:0] pll_ratio(
      input pll_setting_t s);
      logic [FRAC_WIDTH-1:0] f;
      f = s.pll_fraction_enable ? s.frac_mult : '0;
      return {s.integer_mult, f};
   endfunction : pll_ratio

endpackage : osc_pll_pkg

// ==== ref_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none

// Turns oscillator ticks into PLL reference ticks, optionally halved.
module ref_prescaler (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic osc_running,
   input wire logic halve,
   input wire logic osc_tick,
   output logic ref_tick
);
   import osc_pll_pkg::*;

   logic phase_q;
   logic phase_d;
   logic tick_q;
   logic tick_d;

   // Without a running oscillator there is no reference at all.
   assign tick_d = osc_running && osc_tick && (!halve || phase_q);
   assign phase_d = !osc_running ? 1'b0 : (osc_tick ? !phase_q : phase_q);

   // The phase restarts whenever the oscillator stops, so the first
   // halved tick after power-up always lands on the second input tick.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= 1'b0;
         tick_q <= 1'b0;
      end else if (ce) begin
         phase_q <= phase_d;
         tick_q <= tick_d;
      end
   end

   assign ref_tick = tick_q;

endmodule : ref_prescaler

`default_nettype wire

// ==== multiplier_hold.sv ====
`timescale 1ns/1ps
`default_nettype none

// Chooses between the software setting and the receiver's setting.
module multiplier_hold (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic auto_mode,
   input wire osc_pll_pkg::pll_setting_t user_setting,
   input wire osc_pll_pkg::pll_setting_t rx_setting,
   input wire logic rx_update,
   input wire logic rx_stream_active,
   output osc_pll_pkg::pll_setting_t active_setting
);
   import osc_pll_pkg::*;

   pll_setting_t hold_q;
   pll_setting_t hold_d;
   logic take_rx;

   // Updates are only taken while a stream is present; otherwise the
   // last recovered values stay frozen.
   assign take_rx = rx_update && rx_stream_active;
   assign hold_d = take_rx ? rx_setting : hold_q;

   // The held values start at the defaults, so an idle receiver leaves
   // the PLL near its default output.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q <= RST_SETTING;
      end else if (ce) begin
         hold_q <= hold_d;
      end
   end

   assign active_setting = auto_mode ? hold_q : user_setting;

endmodule : multiplier_hold

`default_nettype wire

// ==== osc_pll_clock_control.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Oscillator power-down is bit 3 of 0x1e, reset 1; clock only when up.
// - Oscillator clock selectable for master pin output and auxiliary pin.
// - PLL power-down is bit 0 of 0x1e, reset 1; 0 powers up.
// - Receiver enabled means automatic mode; receiver steers the PLL.
// - In automatic mode derived clocks flagged invalid until receiver relocks.
// - Stream stop in automatic mode freezes integer and fractional values.
// - With no stream, automatic mode keeps default values near 24 MHz.
// - Receiver disabled means manual mode; software settings alone apply.
// - 22-bit fraction from 0x03, 0x04 and 0x05 bits 5:0 with defaults.
// - Integer multiplier in 0x06 bits 3:0, reset 0111.
// - Ratio is integer plus fraction over 2^22; fraction added in fractional mode only.
// - 0x06 bit 4, reset 0, halves the oscillator clock into the PLL.
// - Post divider select in 0x07 bits 1:0, reset 10; auto set by receiver.
// - 0x07 bit 2, reset 1: 0 integer mode, 1 fractional mode.
// - Master clock feeds audio interface and transmitter; pin in or out.
module osc_pll_clock_control (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic soft_reset,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic rx_enable,
   input wire osc_pll_pkg::pll_setting_t rx_setting,
   input wire logic rx_update,
   input wire logic rx_stream_active,
   input wire logic rx_rate_change,
   input wire logic rx_locked,
   input wire logic osc_tick,
   input wire osc_pll_pkg::clock_route_t route,
   output logic osc_enable,
   output logic pll_enable,
   output logic pll_ref_tick,
   output osc_pll_pkg::pll_setting_t pll_setting,
   output logic [25:0] pll_ratio_out,
   output logic auto_mode,
   output logic derived_clocks_valid,
   output logic [1:0] master_clock_src,
   output logic [1:0] aux_clock_src,
   output logic master_pin_oe_n,
   output logic aux_pin_enable,
   output logic master_clock_ok,
   output logic aux_clock_ok,
   output logic config_warning
);
   import osc_pll_pkg::*;

   // Software-visible register state.
   logic [7:0] frac_low_q;
   logic [7:0] frac_mid_q;
   logic [5:0] frac_high_q;
   logic [3:0] integer_q;
   logic halve_q;
   logic [1:0] post_sel_q;
   logic frac_en_q;
   logic osc_pd_q;
   logic pll_pd_q;

   // Decoded write strobes.
   logic wr_frac_low;
   logic wr_frac_mid;
   logic wr_frac_high;
   logic wr_integer;
   logic wr_postdiv;
   logic wr_power;

   assign wr_frac_low = reg_wr && (reg_addr == ADDR_FRAC_LOW);
   assign wr_frac_mid = reg_wr && (reg_addr == ADDR_FRAC_MID);
   assign wr_frac_high = reg_wr && (reg_addr == ADDR_FRAC_HIGH);
   assign wr_integer = reg_wr && (reg_addr == ADDR_INTEGER_PLL_INPUT_HALVE);
   assign wr_postdiv = reg_wr && (reg_addr == ADDR_POSTDIV_FRACMODE);
   assign wr_power = reg_wr && (reg_addr == ADDR_POWER_DOWN);

   // Fraction bytes; the top register only holds six bits.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frac_low_q <= RST_FRAC_LOW;
         frac_mid_q <= RST_FRAC_MID;
         frac_high_q <= RST_FRAC_HIGH;
      end else if (ce) begin
         if (soft_reset) begin
            frac_low_q <= RST_FRAC_LOW;
            frac_mid_q <= RST_FRAC_MID;
            frac_high_q <= RST_FRAC_HIGH;
         end else begin
            if (wr_frac_low) frac_low_q <= reg_wdata;
            if (wr_frac_mid) frac_mid_q <= reg_wdata;
            if (wr_frac_high) frac_high_q <= reg_wdata[5:0];
         end
      end
   end

   // Integer multiplier and input pre-scale select.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         integer_q <= RST_INTEGER;
         halve_q <= RST_HALVE;
      end else if (ce) begin
         if (soft_reset) begin
            integer_q <= RST_INTEGER;
            halve_q <= RST_HALVE;
         end else if (wr_integer) begin
            integer_q <= reg_wdata[INT_WIDTH-1:0];
            halve_q <= reg_wdata[HALVE_BIT];
         end
      end
   end

   // Post divider select and fractional mode select.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         post_sel_q <= RST_POST_SEL;
         frac_en_q <= RST_FRAC_EN;
      end else if (ce) begin
         if (soft_reset) begin
            post_sel_q <= RST_POST_SEL;
            frac_en_q <= RST_FRAC_EN;
         end else if (wr_postdiv) begin
            post_sel_q <= reg_wdata[1:0];
            frac_en_q <= reg_wdata[FRAC_EN_BIT];
         end
      end
   end

   // Power-down bits; the other bits of this register belong to other
   // sections and are neither stored nor driven here.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_pd_q <= RST_OSC_PD;
         pll_pd_q <= RST_PLL_PD;
      end else if (ce) begin
         if (soft_reset) begin
            osc_pd_q <= RST_OSC_PD;
            pll_pd_q <= RST_PLL_PD;
         end else if (wr_power) begin
            osc_pd_q <= reg_wdata[OSC_PD_BIT];
            pll_pd_q <= reg_wdata[PLL_PD_BIT];
         end
      end
   end

   // The software setting as one carrier.
   pll_setting_t user_setting;
   pll_setting_t active_setting;

   assign user_setting = {integer_q, frac_high_q, frac_mid_q, frac_low_q,
      post_sel_q, frac_en_q, halve_q};

   // Mode follows the receiver enable directly.
   logic auto_mode_w;
   pll_setting_t rx_setting_w;

   assign auto_mode_w = rx_enable;
   // The receiver sets the post divider itself; pre-scale and mode
   // select stay as software wrote them.
   assign rx_setting_w = {rx_setting.integer_mult, rx_setting.frac_mult,
      rx_setting.pll_post_divider_sel, frac_en_q, halve_q};

   multiplier_hold u_hold (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .auto_mode(auto_mode_w),
      .user_setting(user_setting),
      .rx_setting(rx_setting_w),
      .rx_update(rx_update),
      .rx_stream_active(rx_stream_active),
      .active_setting(active_setting)
   );

   // Power state of oscillator and PLL.
   logic osc_running;
   logic pll_running;

   assign osc_running = !osc_pd_q;
   // The PLL has no reference without the oscillator, so it only counts
   // as running when both are up.
   assign pll_running = !pll_pd_q && osc_running;

   ref_prescaler u_pll_input_halve (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .osc_running(osc_running),
      .halve(active_setting.pll_input_halve),
      .osc_tick(osc_tick),
      .ref_tick(pll_ref_tick)
   );

   // Clock validity in automatic mode: a rate change drops the flag and
   // only rx_locked raises it again, even a lock held throughout.
   logic valid_q;
   logic valid_d;

   // A rate change in the same cycle as a lock wins; the receiver is
   // expected to drop its lock while it retunes to the new rate.
   assign valid_d = !pll_running ? 1'b0 :
      !auto_mode_w ? 1'b1 :
      rx_rate_change ? 1'b0 :
      rx_locked ? 1'b1 : valid_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid_q <= 1'b0;
      end else if (ce) begin
         valid_q <= valid_d;
      end
   end

   // Source selection for the two clock pins; a clock is usable only if
   // its generator is running and, for PLL clocks, valid.
   function automatic logic source_ok(input logic [1:0] sel,
                                      input logic osc_on,
                                      input logic pll_ok);
      source_ok = (sel == SRC_OSC) ? osc_on :
         ((sel == SRC_CLOCK_A) || (sel == SRC_CLOCK_B)) ? pll_ok : 1'b0;
   endfunction : source_ok

   logic master_ok_w;
   logic aux_ok_w;

   assign master_ok_w = route.master_pin_output &&
      source_ok(route.master_src, osc_running, valid_q);
   assign aux_ok_w = route.aux_pin_enable &&
      source_ok(route.aux_src, osc_running, valid_q);

   // Integer multiplier outside the allowed window is flagged, as is
   // integer mode while the receiver runs; the hardware still obeys.
   logic warn_w;

   assign warn_w = (integer_q < 4'h5) || (integer_q > 4'hd) ||
      (auto_mode_w && !frac_en_q);

   // Registered data outputs.
   logic [1:0] master_src_q;
   logic [1:0] aux_src_q;
   logic master_oe_n_q;
   logic aux_en_q;
   logic master_ok_q;
   logic aux_ok_q;
   logic warn_q;
   pll_setting_t setting_q;
   logic [25:0] ratio_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         master_src_q <= SRC_OSC;
         aux_src_q <= SRC_OSC;
         master_oe_n_q <= 1'b1;
         aux_en_q <= 1'b0;
         master_ok_q <= 1'b0;
         aux_ok_q <= 1'b0;
         warn_q <= 1'b0;
      end else if (ce) begin
         master_src_q <= route.master_src;
         aux_src_q <= route.aux_src;
         master_oe_n_q <= !route.master_pin_output;
         aux_en_q <= route.aux_pin_enable;
         master_ok_q <= master_ok_w;
         aux_ok_q <= aux_ok_w;
         warn_q <= warn_w;
      end
   end

   // The ratio is held at zero while the PLL is down.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         setting_q <= RST_SETTING;
         ratio_q <= '0;
      end else if (ce) begin
         setting_q <= active_setting;
         ratio_q <= pll_running ? pll_ratio(active_setting) : '0;
      end
   end

   // Register read-back; unmapped addresses and unused bits read zero.
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;
   logic rvalid_q;

   assign rd_mux =
      (reg_addr == ADDR_FRAC_LOW) ? frac_low_q :
      (reg_addr == ADDR_FRAC_MID) ? frac_mid_q :
      (reg_addr == ADDR_FRAC_HIGH) ? {2'h0, frac_high_q} :
      (reg_addr == ADDR_INTEGER_PLL_INPUT_HALVE) ? {3'h0, halve_q, integer_q} :
      (reg_addr == ADDR_POSTDIV_FRACMODE) ? {5'h00, frac_en_q, post_sel_q} :
      (reg_addr == ADDR_POWER_DOWN) ? {4'h0, osc_pd_q, 2'h0, pll_pd_q} :
      8'h00;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else if (ce) begin
         rvalid_q <= reg_rd;
         if (reg_rd) rdata_q <= rd_mux;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign osc_enable = osc_running;
   assign pll_enable = !pll_pd_q;
   assign pll_setting = setting_q;
   assign pll_ratio_out = ratio_q;
   assign auto_mode = auto_mode_w;
   assign derived_clocks_valid = valid_q;
   assign master_clock_src = master_src_q;
   assign aux_clock_src = aux_src_q;
   assign master_pin_oe_n = master_oe_n_q;
   assign aux_pin_enable = aux_en_q;
   assign master_clock_ok = master_ok_q;
   assign aux_clock_ok = aux_ok_q;
   assign config_warning = warn_q;

endmodule : osc_pll_clock_control

`default_nettype wire

// ==== osc_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Oscillator stand-in: one tick every DIV cycles while powered up.
module osc_source_model #(
   parameter int DIV = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic osc_enable,
   output logic osc_tick
);
   logic [7:0] cnt_q;

   // A powered-down oscillator makes no edges, so ticks stop at once.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
         osc_tick <= 1'b0;
      end else if (!osc_enable) begin
         cnt_q <= 8'h00;
         osc_tick <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
         osc_tick <= (cnt_q == 8'(DIV - 1));
      end
   end
endmodule : osc_source_model

`default_nettype wire

// ==== osc_pll_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the clock control block.
module osc_pll_checker
   import osc_pll_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic soft_reset,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   input wire logic rx_enable,
   input wire logic rx_rate_change,
   input wire logic rx_locked,
   input wire logic osc_tick,
   input wire osc_pll_pkg::clock_route_t route,
   input wire logic osc_enable,
   input wire logic pll_enable,
   input wire logic pll_ref_tick,
   input wire osc_pll_pkg::pll_setting_t pll_setting,
   input wire logic [25:0] pll_ratio_out,
   input wire logic auto_mode,
   input wire logic derived_clocks_valid,
   input wire logic [1:0] master_clock_src,
   input wire logic master_pin_oe_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Power-down bits act on the enables the cycle after the write.
   chk_osc_pd_write: assert property (
      ce && reg_wr && !soft_reset && reg_addr == ADDR_POWER_DOWN
      |=> osc_enable == !$past(reg_wdata[OSC_PD_BIT]))
      else $error("osc enable does not follow its power-down bit");
   chk_pll_pd_write: assert property (
      ce && reg_wr && !soft_reset && reg_addr == ADDR_POWER_DOWN
      |=> pll_enable == !$past(reg_wdata[PLL_PD_BIT]))
      else $error("pll enable does not follow its power-down bit");
   // A stopped oscillator leaves one cycle of pipeline before silence.
   chk_osc_off_quiet: assert property (
      !osc_enable && !$past(osc_enable) && !$past(osc_enable, 2)
      |-> !pll_ref_tick)
      else $error("reference tick while oscillator is down");
   chk_ref_tick_cause: assert property (
      pll_ref_tick |-> $past(osc_tick))
      else $error("reference tick without an oscillator tick");
   chk_read_answer: assert property (
      ce && reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd))
      else $error("read answer missing or too long");
   chk_auto_mode_map: assert property (
      auto_mode == rx_enable)
      else $error("auto mode does not match receiver enable");
   chk_ratio_sum: assert property (
      $past(pll_enable) && $past(osc_enable) && pll_enable && osc_enable
      |-> pll_ratio_out == {pll_setting.integer_mult,
         pll_setting.pll_fraction_enable ? pll_setting.frac_mult : 22'h0})
      else $error("ratio is not integer plus enabled fraction");
   chk_ratio_idle: assert property (
      !pll_enable && !$past(pll_enable) |-> pll_ratio_out == 26'h0)
      else $error("ratio nonzero while pll is down");
   chk_rate_invalid: assert property (
      rx_enable && rx_rate_change |=> !derived_clocks_valid)
      else $error("clocks still valid after a rate change");
   chk_relock_valid: assert property (
      rx_enable && rx_locked && !rx_rate_change && pll_enable &&
      osc_enable && $past(pll_enable) |=> derived_clocks_valid)
      else $error("clocks not valid after relock");
   chk_route_copy: assert property (
      !$past(rst) |-> master_clock_src == $past(route.master_src) &&
      master_pin_oe_n == !$past(route.master_pin_output))
      else $error("master pin route not copied");
endmodule : osc_pll_checker

bind osc_pll_clock_control osc_pll_checker i_osc_pll_checker (
   .clk(clk), .rst(rst), .ce(ce), .soft_reset(soft_reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .rx_enable(rx_enable),
   .rx_rate_change(rx_rate_change), .rx_locked(rx_locked),
   .osc_tick(osc_tick), .route(route), .osc_enable(osc_enable),
   .pll_enable(pll_enable), .pll_ref_tick(pll_ref_tick),
   .pll_setting(pll_setting), .pll_ratio_out(pll_ratio_out),
   .auto_mode(auto_mode), .derived_clocks_valid(derived_clocks_valid),
   .master_clock_src(master_clock_src), .master_pin_oe_n(master_pin_oe_n)
);

`default_nettype wire

// ==== tb_osc_pll_clock_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_osc_pll_clock_control;
   import osc_pll_pkg::*;
   localparam logic [6:0] AD [6] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h1e};
   localparam logic [7:0] MK [6] = '{8'hff, 8'hff, 8'h3f, 8'h1f, 8'h07, 8'h09};
   localparam logic [7:0] DF [6] = '{8'h21, 8'hfd, 8'h36, 8'h07, 8'h06, 8'h09};
   logic clk, rst, ce, soft_reset, reg_wr, reg_rd, reg_rvalid, rx_enable;
   logic rx_update, rx_stream_active, rx_rate_change, rx_locked, osc_tick;
   logic osc_enable, pll_enable, pll_ref_tick, auto_mode, valid, aux_en;
   logic oe_n, m_ok, a_ok, warn;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [1:0] m_src, a_src;
   logic [25:0] ratio;
   logic [7:0] sw [5];
   pll_setting_t rx_setting, pll_setting;
   clock_route_t route;
   int n_fail = 0;
   int compares = 0;

   osc_source_model #(.DIV(4)) i_osc_source_model (.clk(clk), .rst(rst),
      .osc_enable(osc_enable), .osc_tick(osc_tick));
   osc_pll_clock_control i_osc_pll_clock_control (.clk(clk), .rst(rst),
      .ce(ce), .soft_reset(soft_reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_enable(rx_enable),
      .rx_setting(rx_setting), .rx_update(rx_update),
      .rx_stream_active(rx_stream_active), .rx_rate_change(rx_rate_change),
      .rx_locked(rx_locked), .osc_tick(osc_tick), .route(route),
      .osc_enable(osc_enable), .pll_enable(pll_enable),
      .pll_ref_tick(pll_ref_tick), .pll_setting(pll_setting),
      .pll_ratio_out(ratio), .auto_mode(auto_mode),
      .derived_clocks_valid(valid), .master_clock_src(m_src),
      .aux_clock_src(a_src), .master_pin_oe_n(oe_n),
      .aux_pin_enable(aux_en), .master_clock_ok(m_ok),
      .aux_clock_ok(a_ok), .config_warning(warn));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic finish_test;
      if (n_fail == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // One write strobe, held for exactly the edge that takes it.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read strobe, then a bounded wait for the one-cycle answer.
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      int i;
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      for (i = 0; i < 4; i++) begin
         @(negedge clk);
         if (reg_rvalid === 1'b1) break;
      end
      if (i == 4) begin
         n_fail++;
         finish_test();
      end
      d = reg_rdata;
   endtask : rd

   function automatic logic [25:0] exp_ratio(input logic [3:0] n,
      input logic [21:0] k, input logic en);
      return {n, en ? k : 22'h0};
   endfunction : exp_ratio

   // Manual mode must reflect the software copies alone.
   task automatic chk_manual;
      pll_setting_t e;
      e = {sw[3][3:0], sw[2][5:0], sw[1], sw[0], sw[4][1:0], sw[4][2],
         sw[3][4]};
      `CHK(pll_setting, e)
      `CHK(ratio, exp_ratio(e.integer_mult, e.frac_mult, sw[4][2]))
   endtask : chk_manual

   // Main sequence; the seed is set once so runs repeat exactly.
   initial begin
      logic [7:0] d, wd, nr;
      pll_setting_t rs, e;
      int i, it;
      {rst, ce, rx_enable} = 3'b111;
      {soft_reset, reg_wr, reg_rd, rx_update, rx_stream_active} = 5'h0;
      {rx_rate_change, rx_locked, reg_addr, reg_wdata} = 17'h0;
      rx_setting = RST_SETTING;
      route = '0;
      void'($urandom(2));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK({osc_enable, pll_enable}, 2'b00)
      `CHK(pll_setting, RST_SETTING)
      for (i = 0; i < 6; i++) begin
         rd(AD[i], d);
         `CHK(d, DF[i])
      end
      rd(7'h10, d);
      `CHK(d, 8'h00)
      @(posedge clk) rx_enable <= 1'b0;
      wr(ADDR_POWER_DOWN, 8'hff);
      rd(ADDR_POWER_DOWN, d);
      `CHK(d, 8'h09)
      wr(ADDR_POWER_DOWN, 8'h00);
      for (it = 0; it < 3; it++) begin
         for (i = 0; i < 5; i++) begin
            wd = 8'($urandom) & MK[i];
            if (i == 3) wd[3:0] = 4'(5 + $urandom % 9);
            if (i == 4) wd[2] = it[0];
            wr(AD[i], wd);
            sw[i] = wd;
            rd(AD[i], d);
            `CHK(d, wd)
         end
         repeat (3) @(negedge clk);
         chk_manual();
      end
      // Reference ticks: every oscillator tick, or every second one.
      for (it = 0; it < 2; it++) begin
         sw[3] = {3'h0, it[0], it ? 4'h8 : 4'h3};
         wr(ADDR_INTEGER_PLL_INPUT_HALVE, sw[3]);
         repeat (4) @(negedge clk);
         nr = 8'h00;
         repeat (80) begin
            @(negedge clk);
            nr += 8'(pll_ref_tick);
         end
         `CHK(nr >= (it ? 9 : 19) && nr <= (it ? 11 : 20), 1'b1)
         `CHK(warn, it == 0)
      end
      wr(ADDR_POWER_DOWN, 8'h09);
      repeat (4) @(negedge clk);
      nr = 8'h00;
      repeat (40) begin
         @(negedge clk);
         nr += 8'(pll_ref_tick);
      end
      `CHK(nr, 0)
      `CHK(ratio, 26'h0)
      wr(ADDR_POWER_DOWN, 8'h00);
      sw[4] = 8'h06;
      wr(ADDR_POSTDIV_FRACMODE, sw[4]);
      rs = {4'(5 + $urandom % 9), 22'($urandom), 2'($urandom), 2'h0};
      @(posedge clk);
      {rx_enable, rx_stream_active, rx_locked, rx_update} <= 4'hf;
      rx_setting <= rs;
      @(posedge clk);
      rx_update <= 1'b0;
      repeat (3) @(negedge clk);
      e = {rs.integer_mult, rs.frac_mult, rs.pll_post_divider_sel,
         sw[4][2], sw[3][4]};
      `CHK(auto_mode, 1'b1)
      `CHK(pll_setting, e)
      @(posedge clk);
      rx_rate_change <= 1'b1;
      @(posedge clk);
      rx_rate_change <= 1'b0;
      @(negedge clk);
      `CHK(valid, 1'b0)
      repeat (2) @(negedge clk);
      `CHK(valid, 1'b1)
      @(posedge clk);
      {rx_stream_active, rx_update} <= 2'b01;
      rx_setting <= ~rs;
      @(posedge clk);
      rx_update <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK(pll_setting, e)
      @(posedge clk) rx_enable <= 1'b0;
      repeat (3) @(negedge clk);
      chk_manual();
      // Every source code on both clock pins, pin modes toggled.
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         route <= {2'(i), 2'(3 - i), i[0], i[1]};
         repeat (2) @(negedge clk);
         `CHK({m_src, a_src, oe_n, aux_en}, {2'(i), 2'(3 - i), !i[0], i[1]})
         `CHK({m_ok, a_ok}, {i == 1, i > 1})
      end
      // Software reset beats a write in the same cycle.
      @(posedge clk);
      {soft_reset, reg_wr} <= 2'b11;
      reg_addr <= ADDR_FRAC_LOW;
      reg_wdata <= 8'h5a;
      @(posedge clk);
      {soft_reset, reg_wr} <= 2'b00;
      rd(ADDR_FRAC_LOW, d);
      `CHK(d, RST_FRAC_LOW)
      rd(ADDR_POWER_DOWN, d);
      `CHK(d, 8'h09)
      // A low clock enable must swallow a write strobe entirely.
      @(posedge clk);
      {ce, reg_wr, reg_addr, reg_wdata} <= {2'b01, ADDR_FRAC_LOW, 8'h5a};
      @(posedge clk);
      {ce, reg_wr} <= 2'b10;
      rd(ADDR_FRAC_LOW, d);
      `CHK(d, RST_FRAC_LOW)
      finish_test();
   end
endmodule : tb_osc_pll_clock_control

`default_nettype wire
